// ===== inc/mcss_pkg.sv
// Package of constants and types for the line coding and scrambling path.
package mcss_pkg;

   // ----------------------------------------
   // Key stream register
   // ----------------------------------------
   localparam int           MCSS_LFSR_W    = 11;
   localparam int           MCSS_TAP_A     = 10;
   localparam int           MCSS_TAP_B     = 8;
   localparam logic [10:0]  MCSS_LFSR_INIT = 11'h7FF;
   // Edges from a transmit plain bit to its receive decode in loopback; the receive key lags by this.
   localparam logic [1:0]   MCSS_RX_ALIGN  = 2'h3;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int           MCSS_BAUD_MBD  = 125;
   localparam int           MCSS_CLK_MHZ   = 25;
   localparam int           MCSS_SYM_PER_CLK = 1;

   // ----------------------------------------
   // Line levels
   // ----------------------------------------
   typedef enum logic [1:0] {
      MCSS_LVL_ZERO = 2'h0,
      MCSS_LVL_POS  = 2'h1,
      MCSS_LVL_NEG  = 2'h2
   } mcss_level_t;

   typedef enum logic [3:0] {
      MCSS_PH_Z0 = 4'h1,
      MCSS_PH_P  = 4'h2,
      MCSS_PH_Z1 = 4'h4,
      MCSS_PH_N  = 4'h8
   } mcss_phase_t;

   typedef struct packed {
      logic [10:0] lfsr;
   } mcss_lfsr_st_t;

   typedef struct packed {
      mcss_phase_t   tx_phase;
      logic          tx_nrzi;
      logic          tx_cipher;
      mcss_level_t   line_level;
      mcss_level_t   rx_prev;
      logic          rx_nrzi;
      logic          rx_nrzi_prev;
      logic          rx_plain;
      logic          rx_plain_vld;
      logic [1:0]    rx_hold;
   } mcss_state_t;

endpackage

// ===== logic/mcss_keygen.sv
// Key stream generator built on an 11-bit shift register.
`timescale 1ns/100ps
module mcss_keygen
   import mcss_pkg::*;
#(
   parameter logic [10:0] INIT = MCSS_LFSR_INIT
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic step,
   output logic      key_bit
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   mcss_lfsr_st_t st_reg;
   mcss_lfsr_st_t st_next;
   logic          fb;

   always_comb begin
      st_next = st_reg;
      fb      = st_reg.lfsr[MCSS_TAP_A] ^ st_reg.lfsr[MCSS_TAP_B];
      if (step) begin
         st_next.lfsr = {st_reg.lfsr[MCSS_LFSR_W-2:0], fb};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.lfsr <= INIT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign key_bit = st_reg.lfsr[MCSS_TAP_A];

   a_lfsr_nonzero : assert property (@(posedge clk_sys) disable iff (!rst_n) st_reg.lfsr != '0)
      else $error("Key register reached all zero.");

   a_lfsr_shift : assert property (@(posedge clk_sys) disable iff (!rst_n)
      step && rst_n |=> st_reg.lfsr[0] == ($past(st_reg.lfsr[MCSS_TAP_A]) ^ $past(st_reg.lfsr[MCSS_TAP_B])))
      else $error("Key register feedback wrong.");

endmodule

// ===== logic/mcss_coder.sv
// Scrambler, NRZI and three-level line coder with matching receive path.
`timescale 1ns/100ps
// Function
// - NRZI side toggles level for each one, holds for each zero.
// - Three-level line; one moves to adjacent level, zero holds.
// - One line symbol per bit period at 125 Mbaud; the code sends one symbol per clock, which is 25 Mbaud at the 25 MHz clock.
// - Transmit converts scrambled NRZI into three-level line code.
// - Receive converts three-level symbols to NRZI, then descrambles.
// - Cipher bit is plain bit XOR current key bit.
// - Key register is 11 bits; new bit is XOR of taps 11 and 9.
// - Key register never all zero; reset value has a one.
module mcss_coder
   import mcss_pkg::*;
#(
   parameter logic [10:0] TX_INIT = MCSS_LFSR_INIT,
   parameter logic [10:0] RX_INIT = MCSS_LFSR_INIT
) (
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   input  wire logic  tx_plain,
   output logic       tx_nrzi,
   output mcss_level_t line_tx,
   input  mcss_level_t line_rx,
   output logic       rx_nrzi,
   output logic       rx_plain,
   output logic       rx_plain_vld
);

   // ----------------------------------------
   // Key streams
   // ----------------------------------------
   logic        tx_key;
   logic        rx_key;
   mcss_state_t st_reg;
   mcss_state_t st_next;
   logic        rx_chg;
   logic        rx_nrz;
   logic        rx_step;

   mcss_keygen #(.INIT(TX_INIT)) u_tx_key (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .step    (1'b1),
      .key_bit (tx_key)
   );

   // ----------------------------------------
   // Receive key alignment
   // ----------------------------------------
   // Receive key waits out the loopback path after reset, then steps every clock.
   // A cable delay beyond that path needs a longer alignment count.
   mcss_keygen #(.INIT(RX_INIT)) u_rx_key (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .step    (rx_step),
      .key_bit (rx_key)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      rx_chg  = 1'b0;
      rx_nrz  = 1'b0;
      rx_step = 1'b0;
      // One symbol per clock, clock equals symbol rate.
      st_next.tx_cipher = tx_plain ^ tx_key;
      st_next.tx_nrzi   = st_reg.tx_nrzi ^ st_reg.tx_cipher;
      if (st_next.tx_nrzi != st_reg.tx_nrzi) begin
         case (st_reg.tx_phase)
            MCSS_PH_Z0: begin
               st_next.tx_phase   = MCSS_PH_P;
               st_next.line_level = MCSS_LVL_POS;
            end
            MCSS_PH_P: begin
               st_next.tx_phase   = MCSS_PH_Z1;
               st_next.line_level = MCSS_LVL_ZERO;
            end
            MCSS_PH_Z1: begin
               st_next.tx_phase   = MCSS_PH_N;
               st_next.line_level = MCSS_LVL_NEG;
            end
            MCSS_PH_N: begin
               st_next.tx_phase   = MCSS_PH_Z0;
               st_next.line_level = MCSS_LVL_ZERO;
            end
            default: begin
               st_next.tx_phase   = MCSS_PH_Z0;
               st_next.line_level = MCSS_LVL_ZERO;
            end
         endcase
      end
      rx_chg               = (line_rx != st_reg.rx_prev);
      st_next.rx_prev      = line_rx;
      st_next.rx_nrzi      = st_reg.rx_nrzi ^ rx_chg;
      st_next.rx_nrzi_prev = st_reg.rx_nrzi;
      rx_nrz               = st_reg.rx_nrzi ^ st_reg.rx_nrzi_prev;
      st_next.rx_plain     = rx_nrz ^ rx_key;
      st_next.rx_plain_vld = 1'b1;
      // Count the edges the loopback path needs before the receive key moves.
      rx_step = (st_reg.rx_hold == MCSS_RX_ALIGN);
      if (!rx_step) begin
         st_next.rx_hold = st_reg.rx_hold + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.tx_phase     <= MCSS_PH_Z0;
         st_reg.tx_nrzi      <= 1'b0;
         st_reg.tx_cipher    <= 1'b0;
         st_reg.line_level   <= MCSS_LVL_ZERO;
         st_reg.rx_prev      <= MCSS_LVL_ZERO;
         st_reg.rx_nrzi      <= 1'b0;
         st_reg.rx_nrzi_prev <= 1'b0;
         st_reg.rx_plain     <= 1'b0;
         st_reg.rx_plain_vld <= 1'b0;
         st_reg.rx_hold      <= 2'h0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tx_nrzi      = st_reg.tx_nrzi;
   assign line_tx      = st_reg.line_level;
   assign rx_nrzi      = st_reg.rx_nrzi;
   assign rx_plain     = st_reg.rx_plain;
   assign rx_plain_vld = st_reg.rx_plain_vld;

   // ----------------------------------------
   // Transmit checks and receive output valid check
   // ----------------------------------------
   a_nrzi_toggle : assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.tx_cipher |=> st_reg.tx_nrzi != $past(st_reg.tx_nrzi))
      else $error("NRZI did not toggle on one.");

   a_nrzi_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_reg.tx_cipher |=> $stable(st_reg.tx_nrzi))
      else $error("NRZI changed on zero.");

   a_line_adjacent : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !((st_reg.line_level == MCSS_LVL_POS && $past(st_reg.line_level) == MCSS_LVL_NEG) ||
        (st_reg.line_level == MCSS_LVL_NEG && $past(st_reg.line_level) == MCSS_LVL_POS)))
      else $error("Line jumped across zero.");

   a_line_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(st_reg.tx_nrzi) |-> $changed(st_reg.line_level))
      else $error("Line level did not follow NRZI.");

   a_phase_cycle : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_reg.tx_phase == MCSS_PH_P) && $changed(st_reg.tx_nrzi) |-> $past(st_reg.tx_phase) == MCSS_PH_Z0)
      else $error("Level cycle out of order.");

   a_cipher_xor : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> st_reg.tx_cipher == ($past(tx_plain) ^ $past(tx_key)))
      else $error("Cipher bit wrong.");

   a_nrzi_latency : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && (tx_plain ^ tx_key) |=> ##1 st_reg.tx_nrzi != $past(st_reg.tx_nrzi))
      else $error("NRZI did not follow cipher one.");

   a_line_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_reg.tx_cipher |=> $stable(st_reg.line_level))
      else $error("Line level moved on zero.");

   a_line_cause : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(st_reg.line_level) |-> $changed(st_reg.tx_nrzi))
      else $error("Line level moved without NRZI change.");

   a_phase_onehot : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $onehot(st_reg.tx_phase))
      else $error("Level phase not one-hot.");

   a_phase_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_reg.tx_cipher |=> $stable(st_reg.tx_phase))
      else $error("Level phase moved on zero.");

   a_level_phase : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_reg.tx_phase == MCSS_PH_P) == (st_reg.line_level == MCSS_LVL_POS) &&
      (st_reg.tx_phase == MCSS_PH_N) == (st_reg.line_level == MCSS_LVL_NEG))
      else $error("Line level disagrees with phase.");

   a_sym_rate : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> rx_plain_vld)
      else $error("Output not valid every bit period.");

   // ----------------------------------------
   // Receive checks
   // ----------------------------------------

   a_rx_decode : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (line_rx != st_reg.rx_prev) |=> st_reg.rx_nrzi != $past(st_reg.rx_nrzi))
      else $error("Receive NRZI missed a change.");

   a_rx_descr : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> rx_plain == ($past(st_reg.rx_nrzi) ^ $past(st_reg.rx_nrzi_prev) ^ $past(rx_key)))
      else $error("Descrambled bit wrong.");

   a_rx_prev : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> st_reg.rx_prev == $past(line_rx))
      else $error("Receive level not tracked.");

   a_rx_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (line_rx == st_reg.rx_prev) |=> $stable(st_reg.rx_nrzi))
      else $error("Receive NRZI moved without a change.");

   a_rx_one : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && (line_rx != st_reg.rx_prev) |=> ##1 rx_plain == !$past(rx_key))
      else $error("Level change did not decode as one.");

   a_rx_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && (line_rx == st_reg.rx_prev) |=> ##1 rx_plain == $past(rx_key))
      else $error("Steady level did not decode as zero.");

   a_key_align : assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && (st_reg.rx_hold == MCSS_RX_ALIGN) |-> rx_key == $past(tx_key, 3))
      else $error("Receive key out of phase with transmit key.");

endmodule

// ===== tb/mcss_line_model.sv
// Cable model that loops the line back or injects levels.
`timescale 1ns/100ps
module mcss_line_model
   import mcss_pkg::*;
(
   input  mcss_level_t line_tx,
   input  wire logic   inj,
   input  mcss_level_t inj_lvl,
   output mcss_level_t line_rx
);
   // Zero delay loopback, or injected levels with illegal jumps.
   assign line_rx = inj ? inj_lvl : line_tx;
endmodule

// ===== tb/mcss_coder_tb_top.sv
// Self-checking testbench for the line coding and scrambling path.
`timescale 1ns/100ps
module mcss_coder_tb_top
   import mcss_pkg::*;
;
   logic        clk_sys = 0, rst_n = 0, tx_plain = 0, inj = 0;
   mcss_level_t inj_lvl = MCSS_LVL_ZERO, line_tx, line_rx, lp, lnz, lr1, lr2, want;
   logic        tx_nrzi, rx_nrzi, rx_plain, rx_plain_vld, np, rnp;
   logic [3:0]  ph;
   logic [1:0]  cr;
   logic [10:0] kq, rq;
   int          n_errors = 0, cmp_count = 0, warm, nk, nr;

   always #20 clk_sys = ~clk_sys;

   mcss_coder dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .tx_plain(tx_plain), .tx_nrzi(tx_nrzi),
      .line_tx(line_tx), .line_rx(line_rx), .rx_nrzi(rx_nrzi), .rx_plain(rx_plain),
      .rx_plain_vld(rx_plain_vld));
   mcss_line_model pm_u (.line_tx(line_tx), .inj(inj), .inj_lvl(inj_lvl), .line_rx(line_rx));

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      cmp_count++;
      if (e !== g) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
         n_errors++;
      end
   endtask

   task automatic step(input logic p, input mcss_level_t lv, input logic ij = 1'b0);
      logic k, rk;
      @(posedge clk_sys);
      tx_plain <= p;
      inj_lvl  <= lv;
      inj      <= ij;
      @(negedge clk_sys);
      warm++;
      k = tx_nrzi ^ np ^ ph[1];
      if (warm > 3) begin
         if (nk >= 11) chk("tx_key", {kq[10] ^ kq[8], |kq}, {k, 1'b1});
         kq = {kq[9:0], k};
         nk++;
      end
      chk("line_step", tx_nrzi != np, line_tx != lp);
      if (line_tx != lp) begin
         want = (lp != MCSS_LVL_ZERO) ? MCSS_LVL_ZERO : (lnz == MCSS_LVL_POS ? MCSS_LVL_NEG : MCSS_LVL_POS);
         chk("line_level", want, line_tx);
         if (line_tx != MCSS_LVL_ZERO) lnz = line_tx;
      end
      chk("rx_nrzi", rnp ^ (lr1 != lr2), rx_nrzi);
      rk = rx_plain ^ cr[0];
      if (warm > 4 && !inj) chk("rx_plain", ph[3], rx_plain);
      if (warm > 5) begin
         if (nr >= 11) chk("rx_key", {rq[10] ^ rq[8], |rq}, {rk, 1'b1});
         rq = {rq[9:0], rk};
         nr++;
      end
      chk("rx_plain_vld", 1'b1, rx_plain_vld);
      cr  = {cr[0], rx_nrzi ^ rnp};
      ph  = {ph[2:0], p};
      np  = tx_nrzi;
      rnp = rx_nrzi;
      lp  = line_tx;
      lr2 = lr1;
      lr1 = line_rx;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      inj   <= 1'b0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("reset_out", 11'h000, {tx_nrzi, line_tx, rx_nrzi, rx_plain, rx_plain_vld});
      {warm, nk, nr} = '0;
      {np, rnp, ph, cr, kq, rq} = '0;
      {lp, lr1, lr2} = {MCSS_LVL_ZERO, MCSS_LVL_ZERO, MCSS_LVL_ZERO};
      lnz = MCSS_LVL_NEG;
      @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask

   task automatic t_zeros();
      for (int i = 0; i < 40; i++) step(1'b0, MCSS_LVL_ZERO);
   endtask

   task automatic t_mix();
      for (int i = 0; i < 60; i++) step(i[2] ^ i[0] | (i > 30), MCSS_LVL_ZERO);
   endtask

   task automatic t_inject();
      mcss_level_t seq[6] = '{MCSS_LVL_POS, MCSS_LVL_NEG, MCSS_LVL_NEG, MCSS_LVL_ZERO, MCSS_LVL_NEG, MCSS_LVL_POS};
      for (int i = 0; i < 18; i++) step(1'b1, seq[i % 6], 1'b1);
   endtask

   task automatic t_midreset();
      do_reset();
      for (int i = 0; i < 30; i++) step(i[1], MCSS_LVL_ZERO);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #(40 * 2000);
      n_errors++;
      give_verdict();
   end

   initial begin
      do_reset();
      t_zeros();
      t_mix();
      t_inject();
      t_midreset();
      give_verdict();
   end
endmodule
